// File: design/sbp_burst_packer.sv
`include "sbp_params.svh"
// Contract
// - capability B is five bits, b0 lowest, b4 highest
// - B b4 is 0 with dynamic connectivity and 8-bit channel number
// - B b3 is 1 when carrier may change between adjacent slots
// - B b2 is 1 when first-generation forward link is received
// - B b1-b0: 11 none, 01 constant only, 00 both; 10 reserved
// - version is 11 for old, 10 for new; 01 and 00 never sent
// - capability C is eight bits, b0 lowest, b7 highest
// - C b7 is 1 when destination field has standard meaning
// - C b6-b4 carry the mobility support code
// - C b3 is 0 when return-link adaptive coding is supported
// - C b2 is 0 when blocked-sightline countermeasures are supported
// - C b1-b0: 11 none, 10 single, 01 multi carrier; 00 reserved
// - bit 0 is least significant, bit k-1 most significant
// - fields leave strictly in their defined order
// - values and bytes leave most significant bit first
// - payload scrambled by 15-stage generator, 1 + x^14 + x^15
// - scrambling is XOR of payload bit with sequence bit
// - generator stages 1..15 start at 100101010000000
// - first sequence bit meets first bit after the preamble
// - generator reloaded before every burst
// - capA, address, destination, B, version, C, reserved, type
// - final type bit of a signalling burst is 1
module sbp_burst_packer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // burst control
   input wire logic burstStart,
   output logic busy,
   // capability A, address, destination
   input wire logic [`SBP_CAPA_W-1:0] capA,
   input wire logic [`SBP_ADDR_W-1:0] terminalAddr,
   input wire logic [`SBP_DEST_W-1:0] signallingDestinationField,
   // capability B settings
   input wire logic dynConnSupported,
   input wire logic adjacentSlotHop,
   input wire logic fwdGen1Capable,
   input wire sbp_pkg::sbp_code2_t fwdGen2Code,
   // version
   input wire sbp_pkg::sbp_code2_t protoVersion,
   // capability C settings
   input wire logic destinationFieldMeaningFlag,
   input wire logic [2:0] mobilityCode,
   input wire logic adaptiveReturnSupported,
   input wire logic blockedSightlineSupported,
   input wire sbp_pkg::sbp_code2_t meshCode,
   // serial output to the channel coder
   output logic bitValid,
   output logic bitData,
   output logic bitFirst,
   output logic bitLast,
   input wire logic bitReady
);
   import sbp_pkg::*;

   // ========================================
   // field sanitizing
   sbp_code2_t fwd2Legal;
   sbp_code2_t verLegal;
   sbp_code2_t meshLegal;
   logic [`SBP_CAPB_W-1:0] capB;
   logic [`SBP_CAPC_W-1:0] capC;
   logic [`SBP_PAYLOAD_W-1:0] payload;

   sbp_field_sanitize u_sanitize (
      .fwd2Req(fwdGen2Code),
      .verReq(protoVersion),
      .meshReq(meshCode),
      .fwd2Out(fwd2Legal),
      .verOut(verLegal),
      .meshOut(meshLegal)
   );

   // ========================================
   // capability assembly
   always_comb begin
      capB = '0;
      capB[`SBP_B_DYNCONN] = ~dynConnSupported;
      capB[`SBP_B_HOP] = adjacentSlotHop;
      capB[`SBP_B_FWD1] = fwdGen1Capable;
      capB[1:0] = fwd2Legal;
      capC = '0;
      capC[`SBP_C_DESTMEAN] = destinationFieldMeaningFlag;
      capC[6:4] = mobilityCode;
      capC[`SBP_C_NOACM] = ~adaptiveReturnSupported;
      capC[`SBP_C_NOBLOCK] = ~blockedSightlineSupported;
      capC[1:0] = meshLegal;
      // first field in the top bits, so shifting MSB-first keeps order
      payload = {capA, terminalAddr, signallingDestinationField, capB,
         verLegal, capC, `SBP_RSVD_VAL, `SBP_TYPE_BIT};
   end

   // ========================================
   // serializer
   sbp_state_t state_ff;
   sbp_state_t nxt_state;
   logic [`SBP_PAYLOAD_W-1:0] shift_ff;
   logic [`SBP_PAYLOAD_W-1:0] nxt_shift;
   logic [`SBP_CNT_W-1:0] cnt_ff;
   logic [`SBP_CNT_W-1:0] nxt_cnt;
   logic bitValid_ff;
   logic nxt_bitValid;
   logic bitData_ff;
   logic nxt_bitData;
   logic bitFirst_ff;
   logic nxt_bitFirst;
   logic bitLast_ff;
   logic nxt_bitLast;
   logic seqBit;
   logic prbsReload;
   logic prbsAdvance;
   logic loadSlot;

   localparam logic [`SBP_CNT_W-1:0] LAST_IDX =
      `SBP_CNT_W'(`SBP_PAYLOAD_W - 1);

   sbp_prbs u_prbs (
      .ref_clk(ref_clk),
      .srst(srst),
      .reload(prbsReload),
      .advance(prbsAdvance),
      .seqBit(seqBit)
   );

   // output slot free when empty or being taken
   assign loadSlot = ~bitValid_ff | bitReady;

   always_comb begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_cnt = cnt_ff;
      nxt_bitValid = bitValid_ff;
      nxt_bitData = bitData_ff;
      nxt_bitFirst = bitFirst_ff;
      nxt_bitLast = bitLast_ff;
      prbsReload = 1'b0;
      prbsAdvance = 1'b0;
      if (bitValid_ff && bitReady) begin
         nxt_bitValid = 1'b0;
      end
      case (state_ff)
         SBP_IDLE: begin
            if (burstStart) begin
               nxt_shift = payload;
               nxt_cnt = '0;
               prbsReload = 1'b1;
               nxt_state = SBP_SEND;
            end
         end
         SBP_SEND: begin
            if (loadSlot) begin
               // MSB leaves first, sequence advances per bit
               nxt_bitData = shift_ff[`SBP_PAYLOAD_W-1] ^ seqBit;
               nxt_bitValid = 1'b1;
               nxt_bitFirst = (cnt_ff == '0);
               nxt_bitLast = (cnt_ff == LAST_IDX);
               nxt_shift = {shift_ff[`SBP_PAYLOAD_W-2:0], 1'b0};
               nxt_cnt = cnt_ff + `SBP_CNT_W'(1);
               prbsAdvance = 1'b1;
               if (cnt_ff == LAST_IDX) begin
                  nxt_state = SBP_IDLE;
               end
            end
         end
         default: begin
            nxt_state = SBP_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_ff <= SBP_IDLE;
         shift_ff <= '0;
         cnt_ff <= '0;
         bitValid_ff <= 1'b0;
         bitData_ff <= 1'b0;
         bitFirst_ff <= 1'b0;
         bitLast_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         cnt_ff <= nxt_cnt;
         bitValid_ff <= nxt_bitValid;
         bitData_ff <= nxt_bitData;
         bitFirst_ff <= nxt_bitFirst;
         bitLast_ff <= nxt_bitLast;
      end
   end

   assign busy = (state_ff != SBP_IDLE) | bitValid_ff;
   assign bitValid = bitValid_ff;
   assign bitData = bitData_ff;
   assign bitFirst = bitFirst_ff;
   assign bitLast = bitLast_ff;
endmodule

// File: design/sbp_field_sanitize.sv
`include "sbp_params.svh"
// =========================================
// code sanitizer: reserved codes become none, version codes 01 and 00 become old (11)
module sbp_field_sanitize (
   // requested codes
   input wire logic [1:0] fwd2Req,
   input wire logic [1:0] verReq,
   input wire logic [1:0] meshReq,
   // legal codes
   output logic [1:0] fwd2Out,
   output logic [1:0] verOut,
   output logic [1:0] meshOut
);
   always_comb begin
      fwd2Out = (fwd2Req == `SBP_FWD2_RSVD) ? `SBP_FWD2_NONE
         : fwd2Req;
      verOut = (verReq[1] == 1'b0) ? `SBP_VER_OLD : verReq;
      meshOut = (meshReq == `SBP_MESH_RSVD) ? `SBP_MESH_NONE
         : meshReq;
   end
endmodule

// File: design/sbp_params.svh
`ifndef SBP_PARAMS_SVH
`define SBP_PARAMS_SVH
// field widths, in order of transmission
`define SBP_CAPA_W 24
`define SBP_ADDR_W 48
`define SBP_DEST_W 16
`define SBP_CAPB_W 5
`define SBP_VER_W 2
`define SBP_CAPC_W 8
`define SBP_RSVD_W 8
`define SBP_TYPE_W 1
`define SBP_PAYLOAD_W 112
`define SBP_CNT_W 7
// burst type identifier value
`define SBP_TYPE_BIT 1'b1
// reserved field contents
`define SBP_RSVD_VAL 8'h00
// capability B positions
`define SBP_B_DYNCONN 4
`define SBP_B_HOP 3
`define SBP_B_FWD1 2
// capability C positions
`define SBP_C_DESTMEAN 7
`define SBP_C_NOACM 3
`define SBP_C_NOBLOCK 2
// codes
`define SBP_FWD2_NONE 2'b11
`define SBP_FWD2_CCM 2'b01
`define SBP_FWD2_BOTH 2'b00
`define SBP_FWD2_RSVD 2'b10
`define SBP_VER_OLD 2'b11
`define SBP_VER_NEW 2'b10
`define SBP_MESH_NONE 2'b11
`define SBP_MESH_RSVD 2'b00
`define SBP_MOB_LOCUPD 3'b000
`define SBP_MOB_NONE 3'b111
// scrambler
`define SBP_PRBS_LEN 15
`define SBP_PRBS_INIT 15'h00a9
`endif

// File: design/sbp_pkg.sv
package sbp_pkg;
   typedef enum logic [1:0] {
      SBP_IDLE,
      SBP_SEND
   } sbp_state_t;
   typedef logic [1:0] sbp_code2_t;
endpackage

// File: design/sbp_prbs.sv
`include "sbp_params.svh"
// =========================================
// 15-stage scrambling sequence generator
module sbp_prbs (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // control
   input wire logic reload,
   input wire logic advance,
   // sequence bit
   output logic seqBit
);
   logic [`SBP_PRBS_LEN-1:0] stage_ff;
   logic [`SBP_PRBS_LEN-1:0] nxt_stage;
   // stage_ff[0] is the first stage, stage_ff[14] the last
   assign seqBit = stage_ff[13] ^ stage_ff[14];
   always_comb begin
      nxt_stage = stage_ff;
      if (reload) begin
         nxt_stage = `SBP_PRBS_INIT;
      end else if (advance) begin
         nxt_stage = {stage_ff[13:0], seqBit};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stage_ff <= `SBP_PRBS_INIT;
      end else begin
         stage_ff <= nxt_stage;
      end
   end
endmodule

// File: verif/sbp_burst_packer_checker.sv
module sbp_burst_packer_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // burst control
   input wire logic burstStart,
   input wire logic busy,
   // serial stream
   input wire logic bitValid,
   input wire logic bitData,
   input wire logic bitFirst,
   input wire logic bitLast,
   input wire logic bitReady
);
   logic [6:0] cnt_ff;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // =====================================
   // accepted-bit counter within a burst
   always_ff @(posedge ref_clk) begin
      if (srst || (burstStart && !busy)) begin
         cnt_ff <= '0;
      end else if (bitValid && bitReady) begin
         cnt_ff <= cnt_ff + 7'h1;
      end
   end
   // =====================================
   // properties
   a_reset_idle: assert property ($fell(srst) |-> !bitValid && !busy)
      else $error("stream active right after reset");
   a_start_answer: assert property (burstStart && !busy |-> ##2 bitValid && bitFirst)
      else $error("first bit not presented two cycles after start");
   a_stall_hold: assert property (bitValid && !bitReady |=>
      bitValid && $stable({bitData, bitFirst, bitLast}))
      else $error("bit changed while stalled");
   a_first_count: assert property (bitFirst |-> bitValid && cnt_ff == 7'h0)
      else $error("first marker not on first bit");
   a_last_count: assert property (bitValid && (bitLast || cnt_ff == 7'h6f)
      |-> bitLast && cnt_ff == 7'h6f)
      else $error("last marker not on bit 112");
   a_last_drop: assert property (bitValid && bitReady && bitLast |=> !bitValid && !busy)
      else $error("stream continues after last bit");
   a_next_bit: assert property (bitValid && bitReady && !bitLast |=>
      bitValid && !bitFirst)
      else $error("gap or restart inside burst");
   a_valid_busy: assert property (bitValid |-> busy)
      else $error("bit valid while not busy");
endmodule

bind sbp_burst_packer sbp_burst_packer_checker i_chk (.ref_clk, .srst,
   .burstStart, .busy, .bitValid, .bitData, .bitFirst, .bitLast, .bitReady);

// File: verif/sbp_burst_packer_tb.sv
module sbp_burst_packer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sbp_pkg::*;
   logic ref_clk = 0, srst = 1, burstStart = 0, stallOn = 0, clr = 0;
   logic busy, bitValid, bitData, bitFirst, bitLast, bitReady;
   logic [102:0] stim = '0, s;
   logic [111:0] frame;
   logic [7:0] nBits;
   int err_total = 0, checked = 0, cyc = 0;
   always #10 ref_clk = ~ref_clk;
   sbp_burst_packer i_dut (.ref_clk, .srst, .burstStart, .busy,
      .capA(stim[102:79]), .terminalAddr(stim[78:31]),
      .signallingDestinationField(stim[30:15]), .dynConnSupported(stim[14]),
      .adjacentSlotHop(stim[13]), .fwdGen1Capable(stim[12]),
      .fwdGen2Code(stim[11:10]), .protoVersion(stim[9:8]),
      .destinationFieldMeaningFlag(stim[7]), .mobilityCode(stim[6:4]),
      .adaptiveReturnSupported(stim[3]), .blockedSightlineSupported(stim[2]),
      .meshCode(stim[1:0]), .bitValid, .bitData, .bitFirst, .bitLast,
      .bitReady);
   sbp_sink_model i_sink (.ref_clk, .srst, .bitValid, .bitData, .bitReady,
      .stallOn, .clr, .frame, .nBits);
   // =====================================
   // expected scrambled burst
   function automatic logic [111:0] exp_frame(logic [102:0] v);
      logic [14:0] st;
      logic [111:0] f;
      logic o;
      st = 15'h00a9;
      f = {v[102:15], ~v[14], v[13:12], v[11:10] == 2'b10 ? 2'b11 : v[11:10],
         v[9] ? v[9:8] : 2'b11, v[7:4], ~v[3], ~v[2],
         v[1:0] == 2'b00 ? 2'b11 : v[1:0], 8'h00, 1'b1};
      for (int i = 111; i >= 0; i--) begin
         o = st[13] ^ st[14];
         st = {st[13:0], o};
         f[i] = f[i] ^ o;
      end
      return f;
   endfunction
   task automatic chk(input logic [111:0] g, input logic [111:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic burst(input logic [102:0] v, input logic stall);
      int n;
      @(negedge ref_clk);
      stim = v;
      stallOn = stall;
      clr = 1;
      burstStart = 1;
      @(negedge ref_clk);
      burstStart = 0;
      clr = 0;
      stim = ~v;
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      chk(frame, exp_frame(v));
      chk(112'(nBits), 112'h70);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         results();
      end
   end
   initial begin
      void'($urandom(32'h52d4));
      repeat (10) @(negedge ref_clk);
      srst = 0;
      // every code of the two- and three-bit fields
      for (int i = 0; i < 8; i++) begin
         s = 103'({$urandom, $urandom, $urandom, $urandom});
         s[11:10] = i[1:0];
         s[9:8] = i[1:0];
         s[1:0] = i[1:0];
         s[6:4] = i[2:0];
         burst(s, i[0]);
      end
      // reset in mid-burst, then a burst must restart the sequence
      burstStart = 1;
      @(negedge ref_clk);
      burstStart = 0;
      repeat (5) @(negedge ref_clk);
      srst = 1;
      repeat (2) @(negedge ref_clk);
      srst = 0;
      chk(112'({bitValid, busy}), 112'h0);
      for (int i = 0; i < 20; i++) begin
         s = 103'({$urandom, $urandom, $urandom, $urandom});
         burst(s, 1'($urandom));
      end
      results();
   end
endmodule

// File: verif/sbp_sink_model.sv
module sbp_sink_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // stream from the packer
   input wire logic bitValid,
   input wire logic bitData,
   output logic bitReady,
   // bench control and capture
   input wire logic stallOn,
   input wire logic clr,
   output logic [111:0] frame,
   output logic [7:0] nBits
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bitReady = 1'b1;
   // =====================================
   // random back-pressure while stalling
   always @(negedge ref_clk) begin
      bitReady <= stallOn ? 1'($urandom) : 1'b1;
   end
   always @(posedge ref_clk) begin
      if (srst || clr) begin
         nBits <= '0;
         frame <= '0;
      end else if (bitValid && bitReady) begin
         frame <= {frame[110:0], bitData};
         nBits <= nBits + 8'h1;
      end
   end
endmodule
